//--- rtl/pfa_cfg.svh
// Offsets, field positions, reset values and timing figures of the flash access block
`ifndef PFA_CFG_SVH
`define PFA_CFG_SVH
// Register offsets on the software port
`define PFA_OFS_ADDR_LO 3'h0
`define PFA_OFS_ADDR_HI 3'h1
`define PFA_OFS_DATA_LO 3'h2
`define PFA_OFS_DATA_HI 3'h3
`define PFA_OFS_CTRL 3'h4
`define PFA_OFS_KEY 3'h5
`define PFA_OFS_STATUS 3'h6
// Bit positions in flash_control_one
`define PFA_CTRL_RD 0
`define PFA_CTRL_WR 1
`define PFA_CTRL_WRITE_ENABLE_BIT 2
`define PFA_CTRL_ERASE 3
`define PFA_CTRL_LATCH 4
`define PFA_CTRL_REGION 6
// Bit positions in the status register
`define PFA_STAT_DONE 0
`define PFA_STAT_IE 1
// Unlock keys
`define PFA_KEY_FIRST 8'h55
`define PFA_KEY_SECOND 8'haa
// Word geometry
`define PFA_WORD_W 14
`define PFA_ERASED 14'h3fff
`define PFA_ROW_WORDS 32
`define PFA_UID_WORDS 4
`define PFA_REV_IDX 4'h5
`define PFA_DEV_IDX 4'h6
`define PFA_CFG_LAST 4'ha
// Reset values
`define PFA_CTRL_RST 8'h00
`define PFA_STAT_RST 8'h00
// Timing: self-timed write or erase, and the clock period, both in ns
`define PFA_OP_TIME_NS 2500000
`define PFA_CLK_NS 25
`endif

//--- rtl/pfa_pkg.sv
// Types shared by the flash access block
package pfa_pkg;
	// Progress through the keyed unlock
	typedef enum logic [1:0] {K_IDLE, K_GOT_FIRST, K_GOT_SECOND} pfa_key_type;
	// Operation engine states
	typedef enum logic [1:0] {E_IDLE, E_RUN, E_WAIT} pfa_eng_type;
	// Kind of array operation
	typedef enum logic [1:0] {OP_ERASE, OP_PROG, OP_BULK, OP_PWORD} pfa_op_type;
	// Indirect pointer access from the CPU
	typedef struct packed {
		logic rd; // Read strobe
		logic wr; // Write attempt, never performed
		logic [15:0] addr; // Pointer address, bit 15 selects flash
	} pfa_ind_req_type;
	// External programmer request
	typedef struct packed {
		logic rd; // Read word
		logic wr; // Program word
		logic bulk; // Bulk erase of everything
		logic [15:0] addr; // Bit 15 selects id and config space
		logic [13:0] data; // Word to program
	} pfa_prog_req_type;
endpackage

//--- rtl/pfa_top.sv
// Program flash access control: register port, unlock, latches, array engine
//
// Functional notes
// - 14-bit words; erase sets ones, program clears
// - 32-word rows; row is smallest erase
// - 32 hidden latches loaded via data pair
// - Partial row programming without prior erase allowed
// - Self-programming: word write, row erase only
// - Indirect read: one cycle stall, one byte
// - Indirect writes and erases are ignored
// - Ids/config read-only; user ids writable
// - Register writes blocked on protected memory
// - Region bit picks main or id space
// - Read stalls CPU, data next cycle
// - Data pair holds until read or write
// - Read bit clears itself on completion
// - Erase, latch load, program need unlock
// - Stall until operation ends, then resume
// - Code protect blocks programmer; bulk clears
// - Write protect blocks self-write, not programmer
// - Write and erase timed internally
// - Protected erase clears write bit, skipped
// - Erase done sets flag; enable raises irq
// - Programming never erases automatically
//
// The register addresses and the plain strobed port were left to the implementer.
`timescale 1ns/10ps
`include "pfa_cfg.svh"

module pfa_top #(
	parameter int AW = 13, // Main array word address width
	parameter int OP_CYCLES = (`PFA_OP_TIME_NS + `PFA_CLK_NS - 1) / `PFA_CLK_NS, // Op time
	parameter logic [13:0] REV_ID = 14'h0001, // Arbitrary revision value
	parameter logic [13:0] DEV_ID = 14'h0a5a // Arbitrary device value
) (
	input wire logic clk_sys, // System clock
	input wire logic rst, // Asynchronous reset, active high
	input wire logic [2:0] addr, // Register address
	input wire logic [7:0] wdata, // Register write data
	input wire logic wr, // Register write strobe
	input wire logic rd, // Register read strobe
	output logic [7:0] rdata, // Read data, cycle after strobe
	input wire pfa_pkg::pfa_ind_req_type ind_req, // Indirect pointer access
	output logic [7:0] ind_rdata, // Indirect read byte
	output logic cpu_stall, // CPU suspended
	output logic flash_irq, // Done flag gated by enable
	input wire logic [1:0] write_protect_range, // Protected part of main array
	input wire logic code_protect_bit, // High protects from programmer
	input wire pfa_pkg::pfa_prog_req_type prog_req, // Programmer request
	output logic [13:0] prog_rdata, // Programmer read word
	output logic prog_busy // Engine busy
);
	////////////////////////////////////////////////////////////////
	// Declarations
	localparam int TW = $clog2(OP_CYCLES + 1); // Timer width
	localparam logic [TW-1:0] OP_LOAD = TW'(OP_CYCLES - 1); // Timer reload
	logic [13:0] mem [0:(1<<AW)-1]; // Main array
	logic [13:0] cfgmem [0:15]; // Id and config space
	logic [13:0] latch [0:`PFA_ROW_WORDS-1]; // Hidden write latches
	logic [7:0] flash_address_low; // Address low byte
	logic [6:0] flash_address_high; // Address high bits
	logic [7:0] flash_data_low; // Data low byte
	logic [5:0] flash_data_high; // Data high bits
	logic [7:0] flash_control_one; // Control bits
	logic flash_done_flag; // Sticky completion flag
	logic flash_done_irq_enable; // Completion interrupt enable
	logic cp_state; // Code protection in force
	logic cp_loaded; // Strap already sampled
	pfa_pkg::pfa_key_type key_state; // Unlock progress
	pfa_pkg::pfa_eng_type eng_state; // Engine state
	pfa_pkg::pfa_op_type eng_op; // Running operation
	logic eng_cfg; // Engine targets id space
	logic eng_cpu; // Engine started by software
	logic [14:0] eng_addr; // Current word index
	logic [14:0] eng_last; // Final word index
	logic [13:0] eng_word; // Programmer word
	logic [TW-1:0] eng_timer; // Self-timing counter
	logic read_now; // Software read request
	logic ctrl_wr; // Write of control register
	logic start_req; // Unlocked write-start
	logic target_ok; // Target may be written
	logic [14:0] word_addr; // Current register address
	logic row_op; // Erase or program request
	logic latch_op; // Latch load request
	logic op_done; // Engine finishes this cycle
	logic next_stall; // Next stall value

	////////////////////////////////////////////////////////////////
	// Helpers
	// Protected part of the main array for a given range code
	function automatic logic wp_hit(input logic [14:0] a, input logic [1:0] r);
		logic [14:0] top;
		top = 15'(1 << AW);
		case (r)
			2'b00: wp_hit = 1'b1; // All protected
			2'b01: wp_hit = a < (top >> 1); // Lower half
			2'b10: wp_hit = a < (top >> 2); // Lower quarter
			default: wp_hit = 1'b0; // None
		endcase
	endfunction

	// Read of id and config space
	function automatic logic [13:0] cfg_read(input logic [3:0] i, input logic [13:0] v);
		if (i == `PFA_REV_IDX) begin
			cfg_read = REV_ID;
		end else if (i == `PFA_DEV_IDX) begin
			cfg_read = DEV_ID;
		end else if (i < 4'(`PFA_UID_WORDS) || (i > `PFA_DEV_IDX && i <= `PFA_CFG_LAST)) begin
			cfg_read = v;
		end else begin
			cfg_read = 14'h0000;
		end
	endfunction

	////////////////////////////////////////////////////////////////
	// Request decode
	assign word_addr = {flash_address_high, flash_address_low};
	assign ctrl_wr = wr && addr == `PFA_OFS_CTRL;
	assign read_now = ctrl_wr && wdata[`PFA_CTRL_RD];
	assign start_req = ctrl_wr && wdata[`PFA_CTRL_WR] && wdata[`PFA_CTRL_WRITE_ENABLE_BIT]
		&& key_state == pfa_pkg::K_GOT_SECOND && eng_state == pfa_pkg::E_IDLE;
	assign latch_op = start_req && wdata[`PFA_CTRL_LATCH] && !wdata[`PFA_CTRL_ERASE];
	assign row_op = start_req && !latch_op;
	// Id space: only user ids writable; main: write protect applies
	assign target_ok = wdata[`PFA_CTRL_REGION] ? word_addr[14:5] == 10'h000
		: (!wp_hit(word_addr, write_protect_range) && word_addr < 15'(1 << AW));
	assign op_done = eng_state == pfa_pkg::E_WAIT && eng_timer == '0;

	////////////////////////////////////////////////////////////////
	// Unlock sequence tracker
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			key_state <= pfa_pkg::K_IDLE;
		end else if (wr) begin
			// Any other write breaks the sequence
			if (addr == `PFA_OFS_KEY && wdata == `PFA_KEY_FIRST) begin
				key_state <= pfa_pkg::K_GOT_FIRST;
			end else if (addr == `PFA_OFS_KEY && wdata == `PFA_KEY_SECOND
				&& key_state == pfa_pkg::K_GOT_FIRST) begin
				key_state <= pfa_pkg::K_GOT_SECOND;
			end else begin
				key_state <= pfa_pkg::K_IDLE;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Address registers
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			flash_address_low <= 8'h00;
			flash_address_high <= 7'h00;
		end else if (wr && addr == `PFA_OFS_ADDR_LO) begin
			flash_address_low <= wdata;
		end else if (wr && addr == `PFA_OFS_ADDR_HI) begin
			flash_address_high <= wdata[6:0];
		end
	end

	////////////////////////////////////////////////////////////////
	// Data pair: loaded by a read or by software, else held
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			flash_data_low <= 8'h00;
			flash_data_high <= 6'h00;
		end else if (read_now) begin
			// Word ready in the very next cycle
			if (wdata[`PFA_CTRL_REGION]) begin
				{flash_data_high, flash_data_low} <= word_addr[14:4] == 11'h000
					? cfg_read(word_addr[3:0], cfgmem[word_addr[3:0]]) : 14'h0000;
			end else begin
				{flash_data_high, flash_data_low} <= word_addr < 15'(1 << AW)
					? mem[word_addr[AW-1:0]] : 14'h0000;
			end
		end else if (wr && addr == `PFA_OFS_DATA_LO) begin
			flash_data_low <= wdata;
		end else if (wr && addr == `PFA_OFS_DATA_HI) begin
			flash_data_high <= wdata[5:0];
		end
	end

	////////////////////////////////////////////////////////////////
	// Control register
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			flash_control_one <= `PFA_CTRL_RST;
		end else if (ctrl_wr) begin
			flash_control_one <= wdata & 8'h5c;
			// Write bit only shows for a real row operation
			flash_control_one[`PFA_CTRL_WR] <= row_op && target_ok;
		end else if (op_done) begin
			flash_control_one[`PFA_CTRL_WR] <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////
	// Status: done flag, set wins over clear
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			flash_done_flag <= 1'b0;
			flash_done_irq_enable <= 1'b0;
		end else begin
			if (wr && addr == `PFA_OFS_STATUS) begin
				flash_done_irq_enable <= wdata[`PFA_STAT_IE];
			end
			if (op_done && eng_cpu) begin
				flash_done_flag <= 1'b1;
			end else if (wr && addr == `PFA_OFS_STATUS && !wdata[`PFA_STAT_DONE]) begin
				flash_done_flag <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Register read port
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rdata <= 8'h00;
		end else if (rd) begin
			case (addr)
				`PFA_OFS_ADDR_LO: rdata <= flash_address_low;
				`PFA_OFS_ADDR_HI: rdata <= {1'b0, flash_address_high};
				`PFA_OFS_DATA_LO: rdata <= flash_data_low;
				`PFA_OFS_DATA_HI: rdata <= {2'b00, flash_data_high};
				`PFA_OFS_CTRL: rdata <= flash_control_one;
				`PFA_OFS_STATUS: rdata <= {6'h00, flash_done_irq_enable, flash_done_flag};
				default: rdata <= 8'h00; // Key register and unmapped
			endcase
		end else begin
			rdata <= 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////
	// Write latches, loaded only after unlock
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < `PFA_ROW_WORDS; i++) begin
				latch[i] <= `PFA_ERASED;
			end
		end else if (latch_op) begin
			latch[word_addr[4:0]] <= {flash_data_high, flash_data_low};
		end else if (op_done && eng_op == pfa_pkg::OP_PROG) begin
			// Emptied latches leave unwritten words alone next time
			for (int i = 0; i < `PFA_ROW_WORDS; i++) begin
				latch[i] <= `PFA_ERASED;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Code protection: strap caught after reset, cleared by bulk erase
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cp_state <= 1'b1;
			cp_loaded <= 1'b0;
		end else if (!cp_loaded) begin
			cp_state <= code_protect_bit;
			cp_loaded <= 1'b1;
		end else if (op_done && eng_op == pfa_pkg::OP_BULK) begin
			cp_state <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////
	// Operation engine: step words, then self-time
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			eng_state <= pfa_pkg::E_IDLE;
			eng_op <= pfa_pkg::OP_ERASE;
			eng_cfg <= 1'b0;
			eng_cpu <= 1'b0;
			eng_addr <= 15'h0000;
			eng_last <= 15'h0000;
			eng_word <= 14'h0000;
			eng_timer <= '0;
		end else begin
			case (eng_state)
				pfa_pkg::E_IDLE: begin
					if (row_op && target_ok) begin
						// Row erase or row program; never a bulk erase
						eng_op <= wdata[`PFA_CTRL_ERASE] ? pfa_pkg::OP_ERASE
							: pfa_pkg::OP_PROG;
						eng_cfg <= wdata[`PFA_CTRL_REGION];
						eng_cpu <= 1'b1;
						eng_addr <= {word_addr[14:5], 5'h00};
						eng_last <= wdata[`PFA_CTRL_REGION] ? 15'(`PFA_UID_WORDS - 1)
							: {word_addr[14:5], 5'h1f};
						eng_state <= pfa_pkg::E_RUN;
					end else if (prog_req.bulk) begin
						eng_op <= pfa_pkg::OP_BULK;
						eng_cfg <= 1'b0;
						eng_cpu <= 1'b0;
						eng_addr <= 15'h0000;
						eng_last <= 15'((1 << AW) - 1);
						eng_state <= pfa_pkg::E_RUN;
					end else if (prog_req.wr && !cp_state) begin
						// Programmer ignores write protection
						eng_op <= pfa_pkg::OP_PWORD;
						eng_cfg <= prog_req.addr[15];
						eng_cpu <= 1'b0;
						eng_addr <= prog_req.addr[14:0];
						eng_last <= prog_req.addr[14:0];
						eng_word <= prog_req.data;
						eng_state <= pfa_pkg::E_RUN;
					end
				end
				pfa_pkg::E_RUN: begin
					if (eng_addr == eng_last) begin
						eng_timer <= OP_LOAD;
						eng_state <= pfa_pkg::E_WAIT;
					end else begin
						eng_addr <= eng_addr + 15'h0001;
					end
				end
				pfa_pkg::E_WAIT: begin
					if (eng_timer == '0) begin
						eng_state <= pfa_pkg::E_IDLE;
					end else begin
						eng_timer <= eng_timer - TW'(1);
					end
				end
				default: eng_state <= pfa_pkg::E_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// Array cells: erase drives ones, program only clears bits
	always_ff @(posedge clk_sys) begin
		if (eng_state == pfa_pkg::E_RUN) begin
			case (eng_op)
				pfa_pkg::OP_ERASE: begin
					if (eng_cfg) begin
						cfgmem[eng_addr[3:0]] <= `PFA_ERASED;
					end else begin
						mem[eng_addr[AW-1:0]] <= `PFA_ERASED;
					end
				end
				pfa_pkg::OP_PROG: begin
					// AND keeps the old zeros; no erase beforehand
					if (eng_cfg) begin
						cfgmem[eng_addr[3:0]] <= cfgmem[eng_addr[3:0]]
							& latch[eng_addr[4:0]];
					end else begin
						mem[eng_addr[AW-1:0]] <= mem[eng_addr[AW-1:0]]
							& latch[eng_addr[4:0]];
					end
				end
				pfa_pkg::OP_BULK: begin
					mem[eng_addr[AW-1:0]] <= `PFA_ERASED;
					if (eng_addr < 15'h0010) begin
						cfgmem[eng_addr[3:0]] <= `PFA_ERASED;
					end
				end
				default: begin
					if (eng_cfg) begin
						cfgmem[eng_addr[3:0]] <= cfgmem[eng_addr[3:0]] & eng_word;
					end else begin
						mem[eng_addr[AW-1:0]] <= mem[eng_addr[AW-1:0]] & eng_word;
					end
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// Indirect pointer reads; writes through this path do nothing
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ind_rdata <= 8'h00;
		end else if (ind_req.rd) begin
			// Only the flash window answers, low byte of the word
			ind_rdata <= (ind_req.addr[15] && ind_req.addr[14:0] < 15'(1 << AW))
				? mem[ind_req.addr[AW-1:0]][7:0] : 8'h00;
		end
	end
	// ind_req.wr is deliberately left without effect

	////////////////////////////////////////////////////////////////
	// Programmer reads, refused under code protection
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			prog_rdata <= 14'h0000;
		end else if (prog_req.rd) begin
			if (cp_state) begin
				prog_rdata <= 14'h0000;
			end else if (prog_req.addr[15]) begin
				prog_rdata <= cfg_read(prog_req.addr[3:0], cfgmem[prog_req.addr[3:0]]);
			end else begin
				prog_rdata <= mem[prog_req.addr[AW-1:0]];
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Stall, busy and interrupt outputs
	always_comb begin
		next_stall = read_now || ind_req.rd || latch_op;
		if (row_op && target_ok) begin
			next_stall = 1'b1;
		end else if (eng_state != pfa_pkg::E_IDLE && eng_cpu && !op_done) begin
			next_stall = 1'b1;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cpu_stall <= 1'b0;
			prog_busy <= 1'b0;
			flash_irq <= 1'b0;
		end else begin
			cpu_stall <= next_stall;
			prog_busy <= eng_state != pfa_pkg::E_IDLE && !op_done;
			flash_irq <= flash_done_flag && flash_done_irq_enable;
		end
	end

	////////////////////////////////////////////////////////////////
	// Checks
	property p_read_clears;
		@(posedge clk_sys) disable iff (rst)
		read_now |=> !flash_control_one[`PFA_CTRL_RD] && cpu_stall;
	endproperty
	a_read_clears: assert property (p_read_clears) else $error("read bit or stall");

	property p_key_order;
		@(posedge clk_sys) disable iff (rst)
		(wr && addr == `PFA_OFS_KEY && wdata == `PFA_KEY_SECOND
			&& key_state == pfa_pkg::K_IDLE) |=> key_state == pfa_pkg::K_IDLE;
	endproperty
	a_key_order: assert property (p_key_order) else $error("second key out of order");

	property p_no_unlock;
		@(posedge clk_sys) disable iff (rst)
		(ctrl_wr && key_state != pfa_pkg::K_GOT_SECOND) |=> !flash_control_one[`PFA_CTRL_WR]
			&& $stable(eng_state);
	endproperty
	a_no_unlock: assert property (p_no_unlock) else $error("write started without unlock");

	property p_protect;
		@(posedge clk_sys) disable iff (rst)
		(row_op && !target_ok) |=> eng_state == pfa_pkg::E_IDLE && !flash_control_one[`PFA_CTRL_WR];
	endproperty
	a_protect: assert property (p_protect) else $error("protected target started");

	property p_stall_busy;
		@(posedge clk_sys) disable iff (rst)
		(eng_state == pfa_pkg::E_RUN && eng_cpu) |=> cpu_stall;
	endproperty
	a_stall_busy: assert property (p_stall_busy) else $error("cpu not stalled");

	property p_timer_len;
		@(posedge clk_sys) disable iff (rst)
		$rose(eng_state == pfa_pkg::E_WAIT) |-> eng_timer == OP_LOAD;
	endproperty
	a_timer_len: assert property (p_timer_len) else $error("timer reload wrong");

	property p_done_flag;
		@(posedge clk_sys) disable iff (rst)
		(op_done && eng_cpu) |=> flash_done_flag ##1 (flash_irq == flash_done_irq_enable);
	endproperty
	a_done_flag: assert property (p_done_flag) else $error("done flag or irq");

	property p_data_hold;
		@(posedge clk_sys) disable iff (rst)
		(!read_now && !(wr && (addr == `PFA_OFS_DATA_LO || addr == `PFA_OFS_DATA_HI)))
			|=> $stable({flash_data_high, flash_data_low});
	endproperty
	a_data_hold: assert property (p_data_hold) else $error("data pair changed");

	property p_ind_one;
		@(posedge clk_sys) disable iff (rst)
		(ind_req.rd && eng_state == pfa_pkg::E_IDLE && !read_now) |=> cpu_stall;
	endproperty
	a_ind_one: assert property (p_ind_one) else $error("indirect read not stalled");

	property p_cp_read;
		@(posedge clk_sys) disable iff (rst)
		(prog_req.rd && cp_state) |=> prog_rdata == 14'h0000;
	endproperty
	a_cp_read: assert property (p_cp_read) else $error("protected read leaked");
endmodule

//--- sim/pfa_prog_model.sv
// Programmer-side partner: bulk erase and word reads
`timescale 1ns/10ps

module pfa_prog_model (
	input wire logic clk_sys, // System clock
	input wire logic prog_busy, // Engine busy
	input wire logic [13:0] prog_rdata, // Word read back
	output pfa_pkg::pfa_prog_req_type prog_req // Request to block
);
	// Idle request from time zero
	initial begin
		prog_req <= '0;
	end
	// Bulk pulse, then bounded wait for the engine
	task automatic bulk(output logic ok);
		int n;
		n = 0;
		@(posedge clk_sys);
		prog_req.bulk <= 1'b1;
		@(posedge clk_sys);
		prog_req.bulk <= 1'b0;
		do begin
			@(posedge clk_sys);
			#1 n++;
		end while (prog_busy !== 1'b0 && n < 300);
		ok = (n < 300);
	endtask
	// Word read, answer one cycle later
	task automatic read_word(input logic [15:0] a, output logic [13:0] d);
		@(posedge clk_sys);
		prog_req.addr <= a;
		prog_req.rd <= 1'b1;
		@(posedge clk_sys);
		prog_req.rd <= 1'b0;
		#1 d = prog_rdata;
	endtask
endmodule

//--- sim/pfa_top_bench.sv
// Self-checking bench for the flash access block
`timescale 1ns/10ps
`include "pfa_cfg.svh"

module pfa_top_bench;
	logic clk_sys = 1'b0; // Clock
	logic rst = 1'b1; // Reset
	logic [2:0] addr = 3'h0; // Offset
	logic [7:0] wdata = 8'h00; // Write data
	logic wr = 1'b0; // Write strobe
	logic rd = 1'b0; // Read strobe
	logic [7:0] rdata; // Read data
	pfa_pkg::pfa_ind_req_type ind_req = '0; // Indirect access
	logic [7:0] ind_rdata; // Indirect byte
	logic cpu_stall; // CPU held
	logic flash_irq; // Interrupt
	logic [1:0] wprot = 2'h3; // Protected range
	logic cprot = 1'b1; // Code protection strap
	pfa_pkg::pfa_prog_req_type prog_req; // Programmer request
	logic [13:0] prog_rdata; // Programmer word
	logic prog_busy; // Engine busy
	int fail_count = 0; // Mismatches
	int total_checks = 0; // Comparisons
	int cycles = 0; // Timeout count
	logic [7:0] b; // Byte read
	logic [13:0] w; // Word read
	logic ok; // Bulk finished
	logic [18:0] rows [8]; // Offset, written, expected
	// Revision value is arbitrary
	pfa_top #(.AW(6), .OP_CYCLES(8), .REV_ID(14'h0123)) dut_u (.clk_sys(clk_sys), .rst(rst),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .ind_req(ind_req),
		.ind_rdata(ind_rdata), .cpu_stall(cpu_stall), .flash_irq(flash_irq),
		.write_protect_range(wprot), .code_protect_bit(cprot), .prog_req(prog_req),
		.prog_rdata(prog_rdata), .prog_busy(prog_busy));
	pfa_prog_model pm_u (.clk_sys(clk_sys), .prog_busy(prog_busy),
		.prog_rdata(prog_rdata), .prog_req(prog_req));
	////////////////////////////////////////////////////////////////
	// 40 MHz clock
	always #12.5 clk_sys = ~clk_sys;
	// Hang guard
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fail_count++;
			final_report();
		end
	end
	////////////////////////////////////////////////////////////////
	// Compare and count
	task automatic chk(input logic [13:0] got, input logic [13:0] exp);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	// One-cycle register write
	task automatic wreg(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_sys);
		wr <= 1'b0;
		#1;
	endtask
	// One-cycle register read
	task automatic rreg(input logic [2:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_sys);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	// Software word read, main array or id space by g
	task automatic rword(input logic [7:0] a, input logic g, output logic [13:0] x);
		logic [7:0] lo;
		logic [7:0] hi;
		wreg(`PFA_OFS_ADDR_LO, a);
		wreg(`PFA_OFS_ADDR_HI, 8'h00);
		wreg(`PFA_OFS_CTRL, {1'b0, g, 6'h01});
		chk({13'h0, cpu_stall}, 14'h1);
		rreg(`PFA_OFS_DATA_LO, lo);
		rreg(`PFA_OFS_DATA_HI, hi);
		x = {hi[5:0], lo};
	endtask
	// Keyed unlock then control write
	task automatic unlock(input logic [7:0] c);
		wreg(`PFA_OFS_KEY, `PFA_KEY_FIRST);
		wreg(`PFA_OFS_KEY, `PFA_KEY_SECOND);
		wreg(`PFA_OFS_CTRL, c);
	endtask
	// Bounded wait for the stall to end
	task automatic wait_idle();
		int n;
		n = 0;
		while (cpu_stall !== 1'b0 && n < 200) begin
			@(posedge clk_sys);
			#1 n++;
		end
		chk({13'h0, cpu_stall}, 14'h0);
	endtask
	// Counts and verdict
	task automatic final_report();
		$display("Checks %0d, mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		rows = '{{`PFA_OFS_ADDR_LO, 8'h5a, 8'h5a}, {`PFA_OFS_ADDR_HI, 8'h12, 8'h12},
			{`PFA_OFS_DATA_LO, 8'hc3, 8'hc3}, {`PFA_OFS_DATA_HI, 8'h2a, 8'h2a},
			{`PFA_OFS_KEY, 8'h55, 8'h00}, {3'h7, 8'hff, 8'h00},
			{`PFA_OFS_CTRL, 8'h40, 8'h40}, {`PFA_OFS_STATUS, 8'h02, 8'h02}};
		repeat (20) @(posedge clk_sys);
		rst <= 1'b0;
		foreach (rows[i]) begin
			wreg(rows[i][18:16], rows[i][15:8]);
			rreg(rows[i][18:16], b);
			chk({6'h0, b}, {6'h0, rows[i][7:0]});
		end
		// Reset in mid-run
		@(posedge clk_sys);
		rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		rreg(`PFA_OFS_STATUS, b);
		chk({6'h0, b}, {6'h0, `PFA_STAT_RST});
		pm_u.read_word(16'h8005, w);
		chk(w, 14'h0000);
		pm_u.bulk(ok);
		chk({13'h0, ok}, 14'h1);
		pm_u.read_word(16'h8005, w);
		chk(w, 14'h0123);
		// Latch load and row program
		wreg(`PFA_OFS_STATUS, 8'h02);
		wreg(`PFA_OFS_DATA_LO, 8'h34);
		wreg(`PFA_OFS_DATA_HI, 8'h12);
		wreg(`PFA_OFS_ADDR_LO, 8'h03);
		unlock(8'h16);
		unlock(8'h06);
		chk({13'h0, cpu_stall}, 14'h1);
		wait_idle();
		rreg(`PFA_OFS_STATUS, b);
		chk({6'h0, b}, 14'h003);
		chk({13'h0, flash_irq}, 14'h1);
		rword(8'h03, 1'b0, w);
		chk(w, 14'h1234);
		rreg(`PFA_OFS_CTRL, b);
		chk({13'h0, b[0]}, 14'h0);
		// Indirect write attempt, then indirect read
		@(posedge clk_sys);
		ind_req <= {2'b01, 16'h8004};
		@(posedge clk_sys);
		ind_req <= {2'b10, 16'h8003};
		@(posedge clk_sys);
		ind_req <= '0;
		#1 chk({6'h0, ind_rdata}, 14'h034);
		chk({13'h0, cpu_stall}, 14'h1);
		rword(8'h04, 1'b0, w);
		chk(w, 14'h3fff);
		// Id space read of the revision word
		rword(8'h05, 1'b1, w);
		chk(w, 14'h0123);
		// Control write without keys, then broken unlock
		wreg(`PFA_OFS_CTRL, 8'h0e);
		chk({13'h0, cpu_stall}, 14'h0);
		wreg(`PFA_OFS_KEY, `PFA_KEY_FIRST);
		wreg(`PFA_OFS_ADDR_LO, 8'h03);
		wreg(`PFA_OFS_KEY, `PFA_KEY_SECOND);
		wreg(`PFA_OFS_CTRL, 8'h0e);
		chk({13'h0, cpu_stall}, 14'h0);
		// Erase of a protected row
		@(posedge clk_sys);
		wprot <= 2'h0;
		unlock(8'h0e);
		rreg(`PFA_OFS_CTRL, b);
		chk({13'h0, b[1]}, 14'h0);
		rword(8'h03, 1'b0, w);
		chk(w, 14'h1234);
		pm_u.read_word(16'h0003, w);
		chk(w, 14'h1234);
		// Erase with protection lifted
		@(posedge clk_sys);
		wprot <= 2'h3;
		unlock(8'h0e);
		chk({13'h0, cpu_stall}, 14'h1);
		wait_idle();
		rword(8'h03, 1'b0, w);
		chk(w, 14'h3fff);
		final_report();
	end
endmodule
